// ==== common/said_defs.svh ====
// Offsets, field values, reset values and timing counts of the panel block.
// Assumes a 100 MHz hclk; included by the top module and the bench.
`ifndef SAID_DEFS_SVH
`define SAID_DEFS_SVH

`define SAID_CLK_KHZ 100000
`define SAID_HOLD_MS 2000
`define SAID_HOLD_CYC (`SAID_HOLD_MS * `SAID_CLK_KHZ)
`define SAID_FLICK_MS 250
`define SAID_FLICK_CYC (`SAID_FLICK_MS * `SAID_CLK_KHZ)

`define SAID_OFS_CTRL 8'h00
`define SAID_OFS_STAT 8'h04
`define SAID_OFS_MASK 8'h08
`define SAID_OFS_MODE 8'h0C
`define SAID_OFS_EFF 8'h10
`define SAID_OFS_WRDIS 8'h14
`define SAID_OFS_HCLR 8'h18
`define SAID_OFS_INMAP 8'h1C
`define SAID_OFS_OUTMAP 8'h20
`define SAID_OFS_IO 8'h24

`define SAID_CTRL_PWR 0
`define SAID_ST_RAISE 0
`define SAID_ST_CLEAR 1
`define SAID_ST_DETAIL 2
`define SAID_ST_W 3

`define SAID_CM_P 3'h0
`define SAID_CM_PS 3'h1
`define SAID_CM_S 3'h2
`define SAID_CM_ST 3'h3
`define SAID_CM_T 3'h4
`define SAID_CM_TP 3'h5
`define SAID_CM_RST 3'h0

`define SAID_WRDIS_RST 8'h00
`define SAID_WRDIS_EXP 8'h0C
`define SAID_HCLR_GO 8'h01

`define SAID_PIN_SRV_EN 3'h1
`define SAID_PIN_CTL_CHG 3'h2
`define SAID_PIN_CLR 3'h5
`define SAID_PIN_ESTOP 3'h6

`define SAID_SRC_NONE 3'h0
`define SAID_SRC_READY 3'h1
`define SAID_SRC_ZERO_SPD 3'h2
`define SAID_SRC_TRBL 3'h3
`define SAID_SRC_SPD_LIM 3'h4
`define SAID_SRC_TRQ_LIM 3'h5
`define SAID_SRC_SPD_REACH 3'h6
`define SAID_SRC_IN_POS 3'h7
`define SAID_HIST_N 6

`endif

// ==== common/said_pkg.sv ====
// Types shared by the panel block.
// Assumes nothing beyond a SystemVerilog compiler.
package said_pkg;

    typedef enum logic [1:0] {SCR_ALARM, SCR_PARAM, SCR_IOMON} said_scr_t;

    typedef enum logic [1:0] {SUB_POS, SUB_SPD, SUB_TRQ} said_sub_t;

    typedef struct packed {
        logic [7:0] addr;
        logic wr;
    } said_ahb_t;

endpackage

// ==== hw/said_top.sv ====
// Front-panel alarm, parameter and I/O monitor logic with an AHB-Lite slave.
// Assumes buttons and pins synchronous to hclk; hresetn acts as power-up.
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "said_defs.svh"

// Overview of operation
// - Alarm screens show alarm or faulty parameter number in two low digits.
// - Current alarm screen shows no-alarm mark, else flickering alarm number.
// - Six most recent alarms kept newest first; empty slots marked empty.
// - A new alarm switches the display to the current alarm screen.
// - With alarm active on other screens, fourth digit point flashes.
// - Clearable alarm cleared by power cycle, set on current screen, reset input.
// - History-clear parameter erases the alarm history.
// - Set held two seconds on a history screen opens detail screen.
// - Up or down steps to the adjacent history entry.
// - Power-cycle parameters keep old effective value until power cycle.
// - First basic parameter selects control mode, effective after power cycle.
// - Expansion parameters writable only after write-disable parameter permits.
// - I/O monitor lights upper segments for inputs, lower for outputs.
// - Pin functions follow control mode; outputs and all inputs but emergency stop remappable.
module said_top
    import said_pkg::*;
#(
    parameter int N_IN = 8,
    parameter int N_OUT = 4,
    parameter int CNT_W = 32,
    parameter int HOLD_CYC = `SAID_HOLD_CYC,
    parameter int FLICK_CYC = `SAID_FLICK_CYC
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic btn_mode,
    input wire logic btn_up,
    input wire logic btn_down,
    input wire logic btn_set,
    input wire logic alarm_raise,
    input wire logic [7:0] alarm_code,
    input wire logic alarm_cause,
    input wire logic alarm_clearable,
    input wire logic param_err,
    input wire logic [7:0] param_err_no,
    input wire logic [N_IN-1:0] in_pins,
    input wire logic st_inpos,
    input wire logic st_spdreach,
    input wire logic st_tlim,
    input wire logic st_vlim,
    input wire logic st_zspd,
    input wire logic st_ready,
    output logic irq,
    output logic [N_OUT-1:0] out_pins,
    output said_scr_t scr,
    output logic [7:0] disp_code,
    output logic disp_none,
    output logic disp_dark,
    output logic disp_dp4,
    output logic detail,
    output logic [N_IN-1:0] seg_up,
    output logic [N_OUT-1:0] seg_lo
);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    said_ahb_t ap_r;
    logic pend_r;
    logic [`SAID_ST_W-1:0] stat_r, mask_r;
    logic [2:0] mode_pend_r, mode_eff_r;
    logic [7:0] wrdis_r;
    logic [8:0] inmap_r;
    logic [3*N_OUT-1:0] outmap_r;
    logic alm_act_r;
    logic [7:0] alm_code_r;
    logic [7:0] hist_code_r [`SAID_HIST_N];
    logic [`SAID_HIST_N-1:0] hist_vld_r;
    logic [2:0] idx_r;
    logic [7:0] pidx_r;
    logic [CNT_W-1:0] hold_cnt_r, blink_cnt_r;
    logic blink_r, clr_in_q_r;
    logic mode_q_r, up_q_r, down_q_r, set_q_r;
    logic mode_p, up_p, down_p, set_p;
    logic wr_en, rd_stat, pwr_cyc, hclr_w, exp_ok;
    logic clr_req, on_cur, on_hist, hold_on, hold_done;
    logic alarm_clear_input, servo_enable_input;
    logic control_change_input, emergency_stop_input;
    logic [7:0] out_src;
    logic [N_OUT-1:0] pins_nxt;
    logic [31:0] rd_val;
    said_sub_t sub;

    // Button press edges
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_q_r <= 1'b0;
            up_q_r <= 1'b0;
            down_q_r <= 1'b0;
            set_q_r <= 1'b0;
            clr_in_q_r <= 1'b0;
        end
        else
        begin
            mode_q_r <= btn_mode;
            up_q_r <= btn_up;
            down_q_r <= btn_down;
            set_q_r <= btn_set;
            clr_in_q_r <= alarm_clear_input;
        end
    end
    assign mode_p = btn_mode & ~mode_q_r;
    assign up_p = btn_up & ~up_q_r;
    assign down_p = btn_down & ~down_q_r;
    assign set_p = btn_set & ~set_q_r;

    // AHB-Lite slave, one wait state per transfer
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ap_r <= '0;
            pend_r <= 1'b0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= 32'h0;
        end
        else if (pend_r)
        begin
            pend_r <= 1'b0;
            hreadyout <= 1'b1;
            if (!ap_r.wr)
                hrdata <= rd_val;
        end
        else if (hsel && hready && htrans[1])
        begin
            ap_r <= '{addr: haddr[7:0], wr: hwrite};
            pend_r <= 1'b1;
            hreadyout <= 1'b0;
        end
    end
    assign wr_en = pend_r & ap_r.wr;
    assign rd_stat = pend_r & ~ap_r.wr & (ap_r.addr == `SAID_OFS_STAT);
    assign pwr_cyc = wr_en & (ap_r.addr == `SAID_OFS_CTRL) & hwdata[`SAID_CTRL_PWR];
    assign hclr_w = wr_en & (ap_r.addr == `SAID_OFS_HCLR) & (hwdata[7:0] == `SAID_HCLR_GO);
    assign exp_ok = (wrdis_r == `SAID_WRDIS_EXP);

    always_comb
    begin
        case (ap_r.addr)
            `SAID_OFS_STAT: rd_val = 32'(stat_r);
            `SAID_OFS_MASK: rd_val = 32'(mask_r);
            `SAID_OFS_MODE: rd_val = 32'(mode_pend_r);
            `SAID_OFS_EFF: rd_val = {14'h0, scr, alm_code_r, 4'h0, alm_act_r, mode_eff_r};
            `SAID_OFS_WRDIS: rd_val = 32'(wrdis_r);
            `SAID_OFS_INMAP: rd_val = 32'(inmap_r);
            `SAID_OFS_OUTMAP: rd_val = 32'(outmap_r);
            `SAID_OFS_IO: rd_val = 32'({emergency_stop_input, servo_enable_input,
                control_change_input, alarm_clear_input, out_pins, in_pins});
            default: rd_val = 32'h0;
        endcase
    end

    // Parameter image
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mask_r <= '0;
            mode_pend_r <= `SAID_CM_RST;
            mode_eff_r <= `SAID_CM_RST;
            wrdis_r <= `SAID_WRDIS_RST;
            inmap_r <= '0;
            outmap_r <= '0;
        end
        else
        begin
            if (pwr_cyc)
                mode_eff_r <= mode_pend_r;
            if (wr_en && ap_r.addr == `SAID_OFS_MASK)
                mask_r <= hwdata[`SAID_ST_W-1:0];
            if (wr_en && ap_r.addr == `SAID_OFS_MODE)
                mode_pend_r <= hwdata[2:0];
            if (wr_en && ap_r.addr == `SAID_OFS_WRDIS)
                wrdis_r <= hwdata[7:0];
            if (wr_en && exp_ok && ap_r.addr == `SAID_OFS_INMAP)
                inmap_r <= hwdata[8:0];
            if (wr_en && exp_ok && ap_r.addr == `SAID_OFS_OUTMAP)
                outmap_r <= hwdata[3*N_OUT-1:0];
        end
    end

    // Mode-dependent pin functions and remapping
    assign alarm_clear_input = in_pins[inmap_r[2:0] != 3'h0 ? inmap_r[2:0] : `SAID_PIN_CLR];
    assign servo_enable_input = in_pins[inmap_r[5:3] != 3'h0 ? inmap_r[5:3] : `SAID_PIN_SRV_EN];
    assign control_change_input = in_pins[inmap_r[8:6] != 3'h0 ? inmap_r[8:6] : `SAID_PIN_CTL_CHG];
    assign emergency_stop_input = in_pins[`SAID_PIN_ESTOP];

    always_comb
    begin
        case (mode_eff_r)
            `SAID_CM_P: sub = SUB_POS;
            `SAID_CM_PS: sub = control_change_input ? SUB_SPD : SUB_POS;
            `SAID_CM_S: sub = SUB_SPD;
            `SAID_CM_ST: sub = control_change_input ? SUB_TRQ : SUB_SPD;
            `SAID_CM_T: sub = SUB_TRQ;
            `SAID_CM_TP: sub = control_change_input ? SUB_POS : SUB_TRQ;
            default: sub = SUB_POS;
        endcase
    end

    assign out_src = {st_inpos, st_spdreach, st_tlim, st_vlim, alm_act_r, st_zspd, st_ready, 1'b0};

    always_comb
    begin
        logic [2:0] sel;
        sel = `SAID_SRC_NONE;
        pins_nxt = '0;
        for (int i = 0; i < N_OUT; i++)
        begin
            case (i)
                0: sel = sub == SUB_POS ? `SAID_SRC_IN_POS : sub == SUB_SPD ? `SAID_SRC_SPD_REACH : `SAID_SRC_NONE;
                1: sel = sub == SUB_TRQ ? `SAID_SRC_SPD_LIM : `SAID_SRC_TRQ_LIM;
                2: sel = `SAID_SRC_TRBL;
                3: sel = `SAID_SRC_ZERO_SPD;
                default: sel = `SAID_SRC_NONE;
            endcase
            if (outmap_r[3*i+:3] != 3'h0)
                sel = outmap_r[3*i+:3];
            pins_nxt[i] = out_src[sel];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            out_pins <= '0;
        else
            out_pins <= pins_nxt;
    end

    // Current alarm and history
    assign on_cur = (scr == SCR_ALARM) && (idx_r == 3'h0) && !detail;
    assign on_hist = (scr == SCR_ALARM) && (idx_r != 3'h0) && (idx_r != 3'h7);
    assign clr_req = (set_p & on_cur) | (alarm_clear_input & ~clr_in_q_r) | pwr_cyc;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            alm_act_r <= 1'b0;
            alm_code_r <= 8'h00;
        end
        else if (alarm_raise)
        begin
            alm_act_r <= 1'b1;
            alm_code_r <= alarm_code;
        end
        else if (clr_req && !alarm_cause && alarm_clearable)
            alm_act_r <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hist_vld_r <= '0;
            for (int i = 0; i < `SAID_HIST_N; i++)
                hist_code_r[i] <= 8'h00;
        end
        else if (alarm_raise)
        begin
            for (int i = 1; i < `SAID_HIST_N; i++)
            begin
                hist_code_r[i] <= hist_code_r[i-1];
                hist_vld_r[i] <= hist_vld_r[i-1] & ~hclr_w;
            end
            hist_code_r[0] <= alarm_code;
            hist_vld_r[0] <= 1'b1;
        end
        else if (hclr_w)
            hist_vld_r <= '0;
    end

    // Screen navigation
    assign hold_on = btn_set & on_hist & ~detail;
    assign hold_done = hold_on && (hold_cnt_r == CNT_W'(HOLD_CYC - 1));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hold_cnt_r <= '0;
        else if (!hold_on)
            hold_cnt_r <= '0;
        else if (hold_cnt_r != CNT_W'(HOLD_CYC))
            hold_cnt_r <= hold_cnt_r + 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            scr <= SCR_ALARM;
            idx_r <= 3'h0;
            pidx_r <= 8'h00;
            detail <= 1'b0;
        end
        else if (alarm_raise)
        begin
            scr <= SCR_ALARM;
            idx_r <= 3'h0;
            detail <= 1'b0;
        end
        else if (mode_p)
        begin
            case (scr)
                SCR_ALARM: scr <= SCR_PARAM;
                SCR_PARAM: scr <= SCR_IOMON;
                SCR_IOMON: scr <= SCR_ALARM;
                default: scr <= SCR_ALARM;
            endcase
            idx_r <= 3'h0;
            detail <= 1'b0;
        end
        else if (detail && (up_p || down_p))
            detail <= 1'b0;
        else if (up_p || down_p)
        begin
            if (scr == SCR_ALARM)
                idx_r <= up_p ? idx_r + 3'h1 : idx_r - 3'h1;
            else if (scr == SCR_PARAM)
                pidx_r <= up_p ? pidx_r + 8'h01 : pidx_r - 8'h01;
        end
        else if (hold_done)
            detail <= 1'b1;
    end

    // Flicker timebase
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            blink_cnt_r <= '0;
            blink_r <= 1'b0;
        end
        else if (blink_cnt_r == CNT_W'(FLICK_CYC - 1))
        begin
            blink_cnt_r <= '0;
            blink_r <= ~blink_r;
        end
        else
            blink_cnt_r <= blink_cnt_r + 1'b1;
    end

    // Display drive
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            disp_code <= 8'h00;
            disp_none <= 1'b1;
            disp_dark <= 1'b0;
            disp_dp4 <= 1'b0;
            seg_up <= '0;
            seg_lo <= '0;
        end
        else
        begin
            disp_dark <= 1'b0;
            disp_none <= 1'b0;
            disp_code <= 8'h00;
            if (scr == SCR_ALARM && idx_r == 3'h0)
            begin
                disp_code <= alm_code_r;
                disp_none <= ~alm_act_r;
                disp_dark <= alm_act_r & blink_r;
            end
            else if (scr == SCR_ALARM && idx_r == 3'h7)
            begin
                disp_code <= param_err_no;
                disp_none <= ~param_err;
            end
            else if (scr == SCR_ALARM)
            begin
                disp_code <= hist_code_r[idx_r - 3'h1];
                disp_none <= ~hist_vld_r[idx_r - 3'h1];
            end
            else if (scr == SCR_PARAM)
                disp_code <= pidx_r;
            disp_dp4 <= alm_act_r & ~on_cur & blink_r;
            seg_up <= in_pins;
            seg_lo <= out_pins;
        end
    end

    // Sticky events, cleared by a status read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stat_r <= '0;
            irq <= 1'b0;
        end
        else
        begin
            for (int i = 0; i < `SAID_ST_W; i++)
                stat_r[i] <= (stat_r[i] & ~rd_stat) |
                    (i == `SAID_ST_RAISE ? alarm_raise :
                    i == `SAID_ST_CLEAR ? (alm_act_r & clr_req & ~alarm_raise & ~alarm_cause & alarm_clearable) :
                    hold_done);
            irq <= |(stat_r & mask_r);
        end
    end

    alarm_jump_a: assert property (alarm_raise |=> scr == SCR_ALARM && idx_r == 3'h0)
        else $error("alarm did not select current alarm screen");
    code_show_a: assert property (alarm_raise |=> ##1 (!on_cur || disp_code == $past(alarm_code, 2)))
        else $error("alarm number not on low digits");
    no_alarm_a: assert property (on_cur && !alm_act_r |=> disp_none && !disp_dark)
        else $error("no-alarm mark missing");
    hist_order_a: assert property (alarm_raise |=> hist_code_r[1] == $past(hist_code_r[0]) && hist_vld_r[0])
        else $error("history not shifted newest first");
    dp_flash_a: assert property (!alm_act_r |=> !disp_dp4)
        else $error("decimal point lit without alarm");
    set_clear_a: assert property (set_p && on_cur && !alarm_raise && !alarm_cause && alarm_clearable
        |=> !alm_act_r)
        else $error("set press did not clear alarm");
    hist_wipe_a: assert property (hclr_w && !alarm_raise |=> hist_vld_r == '0)
        else $error("history not erased");
    hold_open_a: assert property (hold_done && !alarm_raise && !mode_p && !up_p && !down_p |=> detail)
        else $error("detail screen not opened");
    hist_step_a: assert property (up_p && scr == SCR_ALARM && !detail && !alarm_raise && !mode_p
        |=> idx_r == $past(idx_r) + 3'h1)
        else $error("up did not step history");
    mode_hold_a: assert property (!pwr_cyc |=> $stable(mode_eff_r))
        else $error("control mode changed without power cycle");
    exp_lock_a: assert property (!exp_ok |=> $stable(inmap_r) && $stable(outmap_r))
        else $error("expansion parameter written while locked");
    seg_track_a: assert property (1'b1 |=> seg_up == $past(in_pins) && seg_lo == $past(out_pins))
        else $error("segments do not follow signals");
    pin_pos_a: assert property (mode_eff_r == `SAID_CM_P && outmap_r == '0 |=> out_pins[0] == $past(st_inpos))
        else $error("position mode pin function wrong");
    mode_wrap_a: assert property (mode_p && !alarm_raise && scr == SCR_IOMON |=> scr == SCR_ALARM)
        else $error("mode button did not wrap");

    alarm_clr_c: cover property (alarm_raise ##[1:20] !alm_act_r);
    detail_c: cover property (hold_done ##1 detail);
    irq_c: cover property (irq ##[1:20] !irq);
endmodule

// ==== dv/said_panel_model.sv ====
// Operator model: the four panel buttons and the external alarm clear pin.
// Assumes the bench calls its tasks by hierarchical name; drives just after hclk rises.
`timescale 1ns/1ps
module said_panel_model
(
    input wire logic hclk,
    output logic btn_mode,
    output logic btn_up,
    output logic btn_down,
    output logic btn_set,
    output logic alarm_clear_input
);
    logic [3:0] btn_r;

    assign {btn_set, btn_down, btn_up, btn_mode} = btn_r;

    initial
    begin
        btn_r = 4'h0;
        alarm_clear_input = 1'b0;
    end

    // Press held for some cycles, then a quiet gap so the next press is a new edge
    task automatic press(input int idx, input int hold);
        @(posedge hclk);
        btn_r[idx] <= 1'b1;
        repeat (hold) @(posedge hclk);
        btn_r[idx] <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask

    task automatic clear_pulse();
        @(posedge hclk);
        alarm_clear_input <= 1'b1;
        repeat (2) @(posedge hclk);
        alarm_clear_input <= 1'b0;
        repeat (3) @(posedge hclk);
    endtask
endmodule

// ==== dv/servo_alarm_and_io_display_test.sv ====
// Self-checking bench: AHB-Lite master, status stimulus and operator model around the panel block.
// Assumes said_top built with short hold and flicker counts.
`timescale 1ns/1ps
`include "said_defs.svh"
module servo_alarm_and_io_display_test
    import said_pkg::*;
;
    localparam int HOLD = 20;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, detail;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic btn_mode, btn_up, btn_down, btn_set, alarm_raise, alarm_cause, alarm_clearable, param_err;
    logic [7:0] alarm_code, param_err_no, in_pins, pins_r, seg_up, disp_code;
    logic st_inpos, st_spdreach, st_tlim, st_vlim, st_zspd, st_ready, alarm_clear_input;
    logic disp_none, disp_dark, disp_dp4, seen;
    logic [3:0] out_pins, seg_lo;
    said_scr_t scr;
    logic [7:0] codes [3];
    int num_errors, tests_run, cyc;

    assign hready = hreadyout;
    assign in_pins = {pins_r[7:6], alarm_clear_input, pins_r[4:0]};

    said_top #(.HOLD_CYC(HOLD), .FLICK_CYC(4)) uut
    (
        .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp,
        .hrdata, .btn_mode, .btn_up, .btn_down, .btn_set, .alarm_raise, .alarm_code, .alarm_cause,
        .alarm_clearable, .param_err, .param_err_no, .in_pins, .st_inpos, .st_spdreach, .st_tlim, .st_vlim,
        .st_zspd, .st_ready, .irq, .out_pins, .scr, .disp_code, .disp_none, .disp_dark, .disp_dp4, .detail,
        .seg_up, .seg_lo
    );

    said_panel_model panel
    (
        .hclk, .btn_mode, .btn_up, .btn_down, .btn_set, .alarm_clear_input
    );

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    always @(posedge hclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors = num_errors + 1;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic cmp_bit(input string what, input logic exp, input logic got);
        cmp_val(what, {31'h0, exp}, {31'h0, got});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    // Single word transfer; read data lands in rd
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        #1;
    endtask

    task automatic push(input int idx, input int hold);
        panel.press(idx, hold);
        #1;
    endtask

    task automatic pin_clear();
        panel.clear_pulse();
        #1;
    endtask

    task automatic raise(input logic [7:0] c);
        @(posedge hclk);
        alarm_raise <= 1'b1;
        alarm_code <= c;
        alarm_cause <= 1'b1;
        @(posedge hclk);
        alarm_raise <= 1'b0;
        tick(3);
    endtask

    // Sets seen if the chosen blink output goes high within n cycles
    task automatic watch(input logic sel, input int n);
        seen = 1'b0;
        repeat (n)
        begin
            tick(1);
            seen = seen | (sel ? disp_dp4 : disp_dark);
        end
    endtask

    function automatic logic [31:0] exp_out(input logic [2:0] m);
        logic f0;
        f0 = (m == 3'h0) ? st_inpos : ((m == 3'h2) ? st_spdreach : 1'b0);
        return {28'h0, st_zspd, 1'b0, (m == 3'h4) ? st_vlim : st_tlim, f0};
    endfunction

    initial
    begin
        {hresetn, hsel, hwrite, alarm_raise, alarm_cause, param_err} = 6'h00;
        {haddr, hwdata, htrans, alarm_code, param_err_no, pins_r} = 90'h0;
        {st_inpos, st_spdreach, st_tlim, st_vlim, st_zspd, st_ready} = 6'h00;
        hsize = 3'h2;
        alarm_clearable = 1'b1;
        {num_errors, tests_run, cyc} = 96'h0;
        void'($urandom(32'hF75594B5));
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        tick(1);
        cmp_bit("no alarm", 1'b1, disp_none);
        ahb(0, `SAID_OFS_MASK, 32'h0);
        cmp_val("mask", 32'h0, rd);
        for (int i = 1; i <= 3; i++)
        begin
            push(0, 1);
            cmp_val("scr", i % 3, {30'h0, scr});
        end
        $display("test mode cycle done");
        repeat (8)
        begin
            @(posedge hclk);
            pins_r <= 8'($urandom) & 8'hDF;
            {st_inpos, st_spdreach, st_tlim, st_vlim, st_zspd, st_ready} <= 6'($urandom);
            tick(3);
            cmp_val("seg_up", {24'h0, in_pins}, {24'h0, seg_up});
            cmp_val("seg_lo", {28'h0, out_pins}, {28'h0, seg_lo});
            cmp_val("out P", exp_out(3'h0), {28'h0, out_pins});
        end
        $display("test io monitor done");
        @(posedge hclk);
        param_err <= 1'b1;
        param_err_no <= 8'($urandom_range(1, 99));
        push(2, 1);
        cmp_val("perr", {24'h0, param_err_no}, {24'h0, disp_code});
        cmp_bit("perr mark", 1'b0, disp_none);
        push(1, 1);
        cmp_bit("no alarm", 1'b1, disp_none);
        $display("test param error done");
        ahb(1, `SAID_OFS_MASK, 32'h1);
        for (int i = 0; i < 3; i++)
        begin
            codes[i] = 8'($urandom_range(1, 255));
            push(0, 1);
            raise(codes[i]);
            cmp_val("jump", 32'h0, {30'h0, scr});
            cmp_val("code", {24'h0, codes[i]}, {24'h0, disp_code});
            cmp_bit("irq", 1'b1, irq);
            cmp_bit("trouble", 1'b1, out_pins[2]);
            watch(1'b0, 12);
            cmp_bit("flicker", 1'b1, seen);
            ahb(0, `SAID_OFS_STAT, 32'h0);
            cmp_bit("stat raise", 1'b1, rd[0]);
            cmp_bit("irq off", 1'b0, irq);
            push(0, 1);
            watch(1'b1, 12);
            cmp_bit("dp4", 1'b1, seen);
            push(0, 1);
            push(0, 1);
            push(3, 1);
            ahb(0, `SAID_OFS_EFF, 32'h0);
            cmp_bit("kept", 1'b1, rd[3]);
            @(posedge hclk);
            alarm_cause <= 1'b0;
            case (i)
                0: push(3, 1);
                1: pin_clear();
                default: ahb(1, `SAID_OFS_CTRL, 32'h1);
            endcase
            tick(2);
            ahb(0, `SAID_OFS_EFF, 32'h0);
            cmp_bit("cleared", 1'b0, rd[3]);
        end
        $display("test alarm clear done");
        for (int k = 1; k <= 4; k++)
        begin
            push(1, 1);
            if (k < 4)
                cmp_val("hist", {24'h0, codes[3 - k]}, {24'h0, disp_code});
            else
                cmp_bit("empty", 1'b1, disp_none);
        end
        push(2, 1);
        cmp_val("back", {24'h0, codes[0]}, {24'h0, disp_code});
        push(3, HOLD + 5);
        cmp_bit("detail", 1'b1, detail);
        ahb(0, `SAID_OFS_STAT, 32'h0);
        cmp_bit("stat detail", 1'b1, rd[2]);
        push(1, 1);
        cmp_bit("detail off", 1'b0, detail);
        ahb(1, `SAID_OFS_HCLR, 32'h1);
        push(2, 1);
        cmp_bit("erased", 1'b1, disp_none);
        $display("test history done");
        @(posedge hclk);
        {st_inpos, st_spdreach, st_tlim, st_vlim, st_zspd, st_ready} <= 6'b100000;
        ahb(1, `SAID_OFS_MODE, 32'h2);
        ahb(0, `SAID_OFS_EFF, 32'h0);
        cmp_val("eff old", 32'h0, {29'h0, rd[2:0]});
        cmp_val("out old", exp_out(3'h0), {28'h0, out_pins});
        ahb(1, `SAID_OFS_CTRL, 32'h1);
        ahb(0, `SAID_OFS_EFF, 32'h0);
        cmp_val("eff new", 32'h2, {29'h0, rd[2:0]});
        cmp_val("out S", exp_out(3'h2), {28'h0, out_pins});
        ahb(1, `SAID_OFS_INMAP, 32'h0A3);
        ahb(0, `SAID_OFS_INMAP, 32'h0);
        cmp_val("locked", 32'h0, rd);
        ahb(1, `SAID_OFS_WRDIS, 32'h0C);
        ahb(1, `SAID_OFS_INMAP, 32'h0A3);
        ahb(0, `SAID_OFS_INMAP, 32'h0);
        cmp_val("open", 32'h0A3, rd);
        @(posedge hclk);
        st_vlim <= 1'b1;
        ahb(1, `SAID_OFS_MODE, 32'h4);
        ahb(1, `SAID_OFS_CTRL, 32'h1);
        cmp_val("out T", exp_out(3'h4), {28'h0, out_pins});
        ahb(1, 8'h40, 32'hFFFF);
        ahb(0, 8'h40, 32'h0);
        cmp_val("unmapped", 32'h0, rd);
        cmp_bit("okay", 1'b0, hresp);
        $display("test parameters done");
        final_report();
    end
endmodule
